// file: design/trigger_status.v
`timescale 1ns/100ps
`include "trigger_status_regs.vh"
module trigger_status #(
    parameter TICKS_PER_S = `SEC_PER_TICK_NS / `MCLK_PERIOD_NS
) (
    mclk,
    rst,
    cmd_valid,
    cmd_code,
    cmd_arg,
    cmd_ready_q,
    rsp_ready,
    rsp_valid_q,
    rsp_data_q,
    ext_trig_in,
    alarm_in,
    scan_done,
    ops_busy,
    std_event_in,
    stb_cond_in,
    nv_psc,
    selftest_done,
    selftest_fail,
    meas_start_q,
    wait_trig_q,
    scanning_q,
    srq_q,
    stb_q,
    cls_pulse_q,
    selftest_start_q,
    hist_stat_on_q,
    psc_q
);
    input wire mclk;
    input wire rst;
    input wire cmd_valid; // Host command present
    input wire [4:0] cmd_code; // Command code
    input wire [31:0] cmd_arg; // Command argument
    output reg cmd_ready_q; // Command taken when high
    input wire rsp_ready; // Host takes response
    output reg rsp_valid_q; // Output queue holds a word
    output reg [31:0] rsp_data_q; // Response word
    input wire ext_trig_in; // Rear trigger input
    input wire [3:0] alarm_in; // Alarm levels 1..4
    input wire scan_done; // Scan-list pass finished
    input wire ops_busy; // Other pending operations
    input wire [7:1] std_event_in; // Standard event conditions
    input wire [7:0] stb_cond_in; // Other status byte conditions
    input wire nv_psc; // Stored power-on clear flag
    input wire selftest_done; // Self-test finished pulse
    input wire selftest_fail; // Self-test result
    output reg meas_start_q; // Start one scan pass, pulse
    output reg wait_trig_q; // In wait-for-trigger
    output reg scanning_q; // Scan pass running
    output reg srq_q; // Service request
    output reg [7:0] stb_q; // Live status byte
    output reg cls_pulse_q; // Clears outside event registers
    output reg selftest_start_q; // Starts self-test, pulse
    output reg hist_stat_on_q; // Histogram/statistics enable
    output reg psc_q; // Power-on clear flag

    localparam ST_IDLE = 2'b00; // Not armed
    localparam ST_WAIT = 2'b01; // Wait-for-trigger
    localparam ST_MEAS = 2'b10; // Scan running

    // Setup image: source, slope, infinite, count, interval
    localparam SETUP_W = 44;

    reg [1:0] state_q; // Trigger sequencer
    reg [2:0] src_q; // Selected source
    reg slope_q; // 1 positive slope
    reg [19:0] count_q; // Trigger count
    reg count_inf_q; // Infinite count
    reg [18:0] interval_q; // Timer interval, seconds
    reg [19:0] done_q; // Triggers already taken
    reg [3:0] alarm_prev_q; // Alarm edge history
    reg [7:0] ese_q; // event_summary_enable
    reg [7:0] sre_q; // service_request_enable
    reg [7:0] esr_q; // standard_event_latch
    reg [7:1] ev_prev_q; // Event condition history
    reg opc_pend_q; // Completion command waiting
    reg opcq_pend_q; // Completion query waiting
    reg wai_pend_q; // Wait command holding
    reg tst_pend_q; // Self-test running
    reg [SETUP_W-1:0] setup_mem [1:3]; // User setups

    wire take; // Command accepted this cycle
    wire fire; // Trigger fires this cycle
    wire ext_pending; // Remembered external edge
    wire tim_elapsed; // Timer interval over
    wire [3:0] alarm_rise; // Alarm rising edges
    wire all_done; // No pending work
    wire [7:0] ev_rise; // Event rising conditions
    wire [7:0] stb_live; // Status byte without request bit
    wire [SETUP_W-1:0] setup_now; // Present setup
    wire [SETUP_W-1:0] setup_rcl; // Recalled setup
    reg rsp_push; // Load output queue
    reg [31:0] rsp_word; // Word to load
    reg opcq_d;
    reg wai_d;
    reg tst_d;
    reg rsp_valid_d;

    // Pack the setup image
    function [SETUP_W-1:0] pack_setup;
        input [2:0] src;
        input slope;
        input inf;
        input [19:0] cnt;
        input [18:0] ivl;
        begin
            pack_setup = {src, slope, inf, cnt, ivl};
        end
    endfunction

    assign take = cmd_valid & cmd_ready_q;
    assign setup_now = pack_setup(src_q, slope_q, count_inf_q, count_q, interval_q);
    assign setup_rcl = (cmd_arg[1:0] == `SLOT_DEFAULT) ?
        pack_setup(`DEF_SRC, `DEF_SLOPE_POS, 1'b0, `DEF_COUNT, `DEF_INTERVAL) :
        setup_mem[cmd_arg[1:0]];
    assign alarm_rise = alarm_in & ~alarm_prev_q;
    assign all_done = ~ops_busy & (state_q != ST_MEAS) & ~tst_pend_q;
    assign ev_rise = {std_event_in & ~ev_prev_q, 1'b0};

    // Source gating: each fires only in the wait state
    assign fire = (state_q == ST_WAIT) & (
        (src_q == `SRC_IMM) |
        ((src_q == `SRC_EXT) & ext_pending) |
        ((src_q == `SRC_BUS) & take & (cmd_code == `CMD_TRG)) |
        ((src_q == `SRC_TIM) & tim_elapsed) |
        (src_q[2] & alarm_rise[src_q[1:0]]));

    // Live status byte: event summary, queue, outside conditions
    assign stb_live = {stb_cond_in[7], 1'b0, |(esr_q & ese_q), rsp_valid_q,
        stb_cond_in[3:0]};

    edge_catch u_edge (
        .mclk(mclk),
        .rst(rst),
        .pin(ext_trig_in),
        .slope_pos(slope_q),
        .armed(state_q != ST_IDLE),
        .take(fire),
        .pending_q(ext_pending)
    );

    interval_timer #(
        .TICKS_PER_S(TICKS_PER_S)
    ) u_timer (
        .mclk(mclk),
        .rst(rst),
        .restart(fire),
        .interval(interval_q),
        .elapsed_q(tim_elapsed)
    );

    // Query answers and hold-off decisions
    always @* begin
        rsp_push = 1'b0;
        rsp_word = 32'h00000000;
        opcq_d = opcq_pend_q;
        wai_d = wai_pend_q & ~all_done;
        tst_d = tst_pend_q & ~selftest_done;
        if (opcq_pend_q && all_done) begin
            rsp_push = 1'b1;
            rsp_word = 32'h00000001;
            opcq_d = 1'b0;
        end else if (tst_pend_q && selftest_done) begin
            rsp_push = 1'b1;
            rsp_word = {31'h00000000, selftest_fail};
        end
        if (take) begin
            case (cmd_code)
                `CMD_SRC_GET: begin
                    rsp_push = 1'b1;
                    rsp_word = {29'h00000000, src_q};
                end
                `CMD_ESE_GET: begin
                    rsp_push = 1'b1;
                    rsp_word = {24'h000000, ese_q};
                end
                `CMD_SRE_GET: begin
                    rsp_push = 1'b1;
                    rsp_word = {24'h000000, sre_q};
                end
                `CMD_ESR_GET: begin
                    rsp_push = 1'b1;
                    rsp_word = {24'h000000, esr_q};
                end
                `CMD_STB_GET: begin
                    rsp_push = 1'b1;
                    rsp_word = {24'h000000, stb_q};
                end
                `CMD_PSC_GET: begin
                    rsp_push = 1'b1;
                    rsp_word = {31'h00000000, psc_q};
                end
                `CMD_OPC_GET: opcq_d = 1'b1;
                `CMD_WAI: wai_d = 1'b1;
                `CMD_TST: tst_d = 1'b1;
                default: rsp_push = rsp_push;
            endcase
        end
        rsp_valid_d = rsp_push | (rsp_valid_q & ~rsp_ready);
        if (take && cmd_code == `CMD_CLS && !rsp_push) begin
            rsp_valid_d = 1'b0;
        end
    end

    // Command, trigger and status sequencing
    always @(posedge mclk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            src_q <= `DEF_SRC;
            slope_q <= `DEF_SLOPE_POS;
            count_q <= `DEF_COUNT;
            count_inf_q <= 1'b0;
            interval_q <= `DEF_INTERVAL;
            done_q <= 20'h00000;
            alarm_prev_q <= 4'h0;
            ev_prev_q <= 7'h00;
            esr_q <= 8'h00; // Event registers always clear
            opc_pend_q <= 1'b0;
            opcq_pend_q <= 1'b0;
            wai_pend_q <= 1'b0;
            tst_pend_q <= 1'b0;
            cmd_ready_q <= 1'b1;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 32'h00000000;
            meas_start_q <= 1'b0;
            wait_trig_q <= 1'b0;
            scanning_q <= 1'b0;
            srq_q <= 1'b0;
            stb_q <= 8'h00;
            cls_pulse_q <= 1'b0;
            selftest_start_q <= 1'b0;
            hist_stat_on_q <= 1'b0;
            psc_q <= nv_psc;
            if (nv_psc) begin
                ese_q <= 8'h00; // Enables cleared only with flag set
                sre_q <= 8'h00;
            end
        end else begin
            alarm_prev_q <= alarm_in;
            ev_prev_q <= std_event_in;
            meas_start_q <= fire;
            cls_pulse_q <= 1'b0;
            selftest_start_q <= take & (cmd_code == `CMD_TST);
            opcq_pend_q <= opcq_d;
            wai_pend_q <= wai_d;
            tst_pend_q <= tst_d;
            rsp_valid_q <= rsp_valid_d;
            if (rsp_push) begin
                rsp_data_q <= rsp_word;
            end
            cmd_ready_q <= ~(opcq_d | wai_d | tst_d | rsp_valid_d);
            // Trigger sequencer
            case (state_q)
                ST_WAIT: begin
                    if (fire) begin
                        state_q <= ST_MEAS;
                    end
                end
                ST_MEAS: begin
                    if (scan_done) begin
                        done_q <= done_q + 20'h00001;
                        if (!count_inf_q && done_q + 20'h00001 >= count_q) begin
                            state_q <= ST_IDLE; // Count reached
                        end else begin
                            state_q <= ST_WAIT;
                        end
                    end
                end
                default: begin
                    if (take && cmd_code == `CMD_INIT) begin
                        state_q <= ST_WAIT; // Host arms
                        done_q <= 20'h00000;
                    end
                end
            endcase
            // Event latch: set wins over clear by read
            if (take && (cmd_code == `CMD_ESR_GET || cmd_code == `CMD_CLS)) begin
                esr_q <= ev_rise;
            end else begin
                esr_q <= esr_q | ev_rise;
            end
            if (opc_pend_q && all_done) begin
                esr_q[`ESR_OPC] <= 1'b1;
                opc_pend_q <= 1'b0;
            end
            if (take) begin
                case (cmd_code)
                    `CMD_SRC_SET: src_q <= cmd_arg[2:0];
                    `CMD_SLOPE_SET: slope_q <= cmd_arg[0];
                    `CMD_COUNT_SET: begin
                        if (cmd_arg[19:0] != 20'h00000 && cmd_arg <= {12'h000, `MAX_COUNT}) begin
                            count_q <= cmd_arg[19:0];
                            count_inf_q <= 1'b0;
                        end
                    end
                    `CMD_COUNT_INF: count_inf_q <= 1'b1;
                    `CMD_TIMER_SET: begin
                        if (cmd_arg <= {13'h0000, `MAX_INTERVAL}) begin
                            interval_q <= cmd_arg[18:0];
                        end
                    end
                    `CMD_CLS: cls_pulse_q <= 1'b1;
                    `CMD_ESE_SET: ese_q <= cmd_arg[7:0];
                    `CMD_SRE_SET: sre_q <= cmd_arg[7:0];
                    `CMD_PSC_SET: psc_q <= cmd_arg[0];
                    `CMD_OPC: opc_pend_q <= 1'b1;
                    `CMD_SAV: begin
                        if (cmd_arg[1:0] != `SLOT_DEFAULT) begin
                            setup_mem[cmd_arg[1:0]] <= setup_now;
                        end
                    end
                    `CMD_RCL: begin
                        {src_q, slope_q, count_inf_q, count_q, interval_q} <= setup_rcl;
                        state_q <= ST_IDLE;
                    end
                    `CMD_RST: begin
                        src_q <= `DEF_SRC;
                        slope_q <= `DEF_SLOPE_POS;
                        count_q <= `DEF_COUNT;
                        count_inf_q <= 1'b0;
                        interval_q <= `DEF_INTERVAL;
                        state_q <= ST_IDLE;
                        hist_stat_on_q <= 1'b0;
                    end
                    default: hist_stat_on_q <= hist_stat_on_q;
                endcase
            end
            // Live status and request, follows state each cycle
            wait_trig_q <= (state_q == ST_WAIT) & ~fire;
            scanning_q <= (state_q == ST_MEAS) | fire;
            stb_q <= stb_live | {1'b0, |(stb_live & sre_q), 6'h00};
            srq_q <= |(stb_live & sre_q & ~8'h40);
        end
    end
endmodule // trigger_status

// file: design/trigger_status_regs.vh
`ifndef TRIGGER_STATUS_REGS_VH
`define TRIGGER_STATUS_REGS_VH
// Command codes on cmd_code
`define CMD_NOP 5'h00
`define CMD_SRC_SET 5'h01
`define CMD_SRC_GET 5'h02
`define CMD_SLOPE_SET 5'h03
`define CMD_COUNT_SET 5'h04
`define CMD_COUNT_INF 5'h05
`define CMD_TIMER_SET 5'h06
`define CMD_INIT 5'h07
`define CMD_TRG 5'h08
`define CMD_CLS 5'h09
`define CMD_ESE_SET 5'h0A
`define CMD_ESE_GET 5'h0B
`define CMD_ESR_GET 5'h0C
`define CMD_OPC 5'h0D
`define CMD_OPC_GET 5'h0E
`define CMD_PSC_SET 5'h0F
`define CMD_PSC_GET 5'h10
`define CMD_RCL 5'h11
`define CMD_SAV 5'h12
`define CMD_RST 5'h13
`define CMD_SRE_SET 5'h14
`define CMD_SRE_GET 5'h15
`define CMD_STB_GET 5'h16
`define CMD_TST 5'h17
`define CMD_WAI 5'h18
// Trigger source codes
`define SRC_IMM 3'h0
`define SRC_EXT 3'h1
`define SRC_BUS 3'h2
`define SRC_TIM 3'h3
`define SRC_ALARM1 3'h4
// Defaults and limits
`define DEF_SRC 3'h0
`define DEF_SLOPE_POS 1'h1
`define DEF_COUNT 20'h00001
`define MAX_COUNT 20'hF4240
`define DEF_INTERVAL 19'h0000A
`define MAX_INTERVAL 19'h57E40
`define SEC_PER_TICK_NS 1000000000
`define MCLK_PERIOD_NS 100
// Event bit positions
`define ESR_OPC 0
// Setup slot limits
`define SLOT_DEFAULT 2'h0
`endif

// file: design/edge_catch.v
`timescale 1ns/100ps
module edge_catch (
    mclk,
    rst,
    pin,
    slope_pos,
    armed,
    take,
    pending_q
);
    input wire mclk;
    input wire rst;
    input wire pin; // External trigger pin, synchronous
    input wire slope_pos; // 1 rising, 0 falling
    input wire armed; // Device is not idle
    input wire take; // Trigger consumed this cycle
    output reg pending_q; // One remembered trigger

    reg pin_prev_q; // Previous pin sample
    wire hit;

    // Edge selected by slope
    assign hit = slope_pos ? (pin & ~pin_prev_q) : (~pin & pin_prev_q);

    // Only one pending trigger; extra early edges fold into it
    always @(posedge mclk) begin
        if (rst) begin
            pin_prev_q <= 1'b0;
            pending_q <= 1'b0;
        end else begin
            pin_prev_q <= pin;
            if (!armed) begin
                pending_q <= 1'b0; // Idle: edges ignored
            end else if (hit) begin
                pending_q <= 1'b1; // New edge wins over consumption
            end else if (take) begin
                pending_q <= 1'b0;
            end
        end
    end
endmodule // edge_catch

// file: design/interval_timer.v
`timescale 1ns/100ps
module interval_timer #(
    parameter TICKS_PER_S = 10000000
) (
    mclk,
    rst,
    restart,
    interval,
    elapsed_q
);
    input wire mclk;
    input wire rst;
    input wire restart; // Start of a trigger
    input wire [18:0] interval; // Seconds
    output reg elapsed_q; // Interval since last start is over

    reg [23:0] tick_q; // Sub-second prescaler
    reg [18:0] sec_q; // Whole seconds since start

    // Measures start-to-start; stays elapsed so slow scans run back to back
    always @(posedge mclk) begin
        if (rst || restart) begin
            tick_q <= {23'h000000, restart}; // Restart cycle is the first tick
            sec_q <= 19'h00000;
            elapsed_q <= 1'b0;
        end else begin
            if (sec_q >= interval) begin
                elapsed_q <= 1'b1;
            end
            if (!elapsed_q) begin
                if (tick_q == TICKS_PER_S - 1) begin
                    tick_q <= 24'h000000;
                    sec_q <= sec_q + 19'h00001;
                    if (sec_q + 19'h00001 >= interval) begin
                        elapsed_q <= 1'b1; // One cycle early, so start-to-start is exact
                    end
                end else begin
                    tick_q <= tick_q + 24'h000001;
                end
            end
        end
    end
endmodule // interval_timer

// file: verification/trigger_status_asserts.sv
`timescale 1ns/100ps
`include "trigger_status_regs.vh"
module trigger_status_asserts (
    input wire mclk,
    input wire rst,
    input wire cmd_valid,
    input wire [4:0] cmd_code,
    input wire cmd_ready_q,
    input wire rsp_ready,
    input wire rsp_valid_q,
    input wire [31:0] rsp_data_q,
    input wire nv_psc,
    input wire [7:0] stb_cond_in,
    input wire meas_start_q,
    input wire wait_trig_q,
    input wire scanning_q,
    input wire srq_q,
    input wire [7:0] stb_q,
    input wire selftest_start_q,
    input wire hist_stat_on_q,
    input wire psc_q
);
    // Command accepted at this edge
    wire take = cmd_valid && cmd_ready_q;
    // Plain queries, answered one edge later
    wire ask = take && cmd_code inside {`CMD_SRC_GET, `CMD_ESE_GET, `CMD_ESR_GET,
        `CMD_PSC_GET, `CMD_SRE_GET, `CMD_STB_GET};
    // Queries that stall the bus until work ends
    wire held = take && cmd_code inside {`CMD_OPC_GET, `CMD_TST};
    // One clock domain
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_query_answer: assert property (ask |=> rsp_valid_q && !cmd_ready_q)
        else $error("query not answered on next edge");
    a_wait_blocks: assert property (held |=> !cmd_ready_q)
        else $error("bus not held during pending query");
    a_resp_holds: assert property (rsp_valid_q && !rsp_ready |=> rsp_valid_q && $stable(rsp_data_q))
        else $error("response word lost before taken");
    a_resp_taken: assert property (rsp_valid_q && rsp_ready |=> !rsp_valid_q)
        else $error("response word stays after taken");
    a_queue_blocks: assert property (rsp_valid_q |-> !cmd_ready_q)
        else $error("command accepted while response held");
    a_fire_in_wait: assert property (meas_start_q |-> $past(wait_trig_q)
        || $past(scanning_q) || $past(take && cmd_code == `CMD_INIT, 2))
        else $error("trigger fired outside wait state");
    a_start_scans: assert property (meas_start_q |-> scanning_q)
        else $error("measurement start without scan");
    a_stb_live: assert property (!$past(rst) |-> stb_q[3:0] == $past(stb_cond_in[3:0])
        && stb_q[7] == $past(stb_cond_in[7]))
        else $error("status byte not following conditions");
    a_rst_hist_off: assert property (take && cmd_code == `CMD_RST |=> !hist_stat_on_q)
        else $error("histogram still on after reset command");
    a_psc_loaded: assert property ($fell(rst) |-> psc_q == $past(nv_psc))
        else $error("power-on clear flag not loaded");
    a_selftest_go: assert property (take && cmd_code == `CMD_TST |-> ##[1:2] selftest_start_q)
        else $error("self-test not started");
    // Main scenarios reached
    c_measure: cover property (meas_start_q && scanning_q);
    c_bus_trig: cover property (take && cmd_code == `CMD_TRG && wait_trig_q);
    c_service: cover property (srq_q);
endmodule // trigger_status_asserts
bind trigger_status trigger_status_asserts checker_inst (
    .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_ready_q(cmd_ready_q), .rsp_ready(rsp_ready), .rsp_valid_q(rsp_valid_q),
    .rsp_data_q(rsp_data_q), .nv_psc(nv_psc), .stb_cond_in(stb_cond_in),
    .meas_start_q(meas_start_q), .wait_trig_q(wait_trig_q), .scanning_q(scanning_q),
    .srq_q(srq_q), .stb_q(stb_q), .selftest_start_q(selftest_start_q),
    .hist_stat_on_q(hist_stat_on_q), .psc_q(psc_q));

// file: verification/host_model.sv
`timescale 1ns/100ps
module host_model (
    input wire mclk,
    input wire cmd_ready_q,
    input wire rsp_valid_q,
    input wire [31:0] rsp_data_q,
    output logic cmd_valid,
    output logic [4:0] cmd_code,
    output logic [31:0] cmd_arg,
    output logic rsp_ready
);
    // Extra cycles before a response is taken
    int slow = 0;
    // Idle bus at time zero
    initial {cmd_valid, cmd_code, cmd_arg, rsp_ready} = 0;
    // Held until an edge at which ready is already high
    task automatic xfer(input logic [4:0] c, input logic [31:0] a, input logic q,
        output logic [31:0] d);
        @(posedge mclk) #1;
        {cmd_valid, cmd_code, cmd_arg} = {1'b1, c, a};
        while (!cmd_ready_q) @(posedge mclk) #1;
        @(posedge mclk) #1;
        // Released lines invert so stale values are never reused
        {cmd_valid, cmd_code, cmd_arg} = {1'b0, ~c, ~a};
        while (q && !rsp_valid_q) @(posedge mclk) #1;
        d = rsp_data_q;
        if (q) begin
            repeat (slow) @(posedge mclk) #1;
            rsp_ready = 1;
            @(posedge mclk) #1;
            rsp_ready = 0;
        end
    endtask
endmodule // host_model

// file: verification/trigger_status_test.sv
`timescale 1ns/100ps
`include "trigger_status_regs.vh"
module trigger_status_test;
    // Design inputs
    logic mclk = 0, rst = 1, nv_psc = 1, ext_trig_in = 0, ops_busy = 0, scan_done = 0;
    logic selftest_done = 0, selftest_fail = 0;
    logic [3:0] alarm_in = 4'h0;
    logic [7:1] std_event_in = 7'h00;
    logic [7:0] stb_cond_in = 8'h00;
    // Design outputs and host lines
    wire cmd_valid, cmd_ready_q, rsp_ready, rsp_valid_q, meas_start_q, wait_trig_q;
    wire scanning_q, srq_q, cls_pulse_q, selftest_start_q, hist_stat_on_q, psc_q;
    wire [4:0] cmd_code;
    wire [31:0] cmd_arg, rsp_data_q;
    wire [7:0] stb_q;
    // Bookkeeping
    int n_errors, n_tests, n_meas, cyc, t_last, gap;
    int sc, slen = 3, t0;
    logic [31:0] d;
    // Row: command, query flag, value
    typedef struct packed { logic [4:0] c; logic q; logic [31:0] v; } row_t;
    row_t rows [8] = '{'{`CMD_ESE_SET, 0, 32'h82}, '{`CMD_ESE_GET, 1, 32'h82},
        '{`CMD_SRE_SET, 0, 32'h07}, '{`CMD_SRE_GET, 1, 32'h07},
        '{`CMD_ESE_SET, 0, 32'hFF}, '{`CMD_ESE_GET, 1, 32'hFF},
        '{`CMD_PSC_SET, 0, 32'h0}, '{`CMD_PSC_GET, 1, 32'h0}};
    // Ten-cycle second
    trigger_status #(.TICKS_PER_S(10)) trigger_status_inst (
        .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_arg(cmd_arg), .cmd_ready_q(cmd_ready_q), .rsp_ready(rsp_ready),
        .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q), .ext_trig_in(ext_trig_in),
        .alarm_in(alarm_in), .scan_done(scan_done), .ops_busy(ops_busy),
        .std_event_in(std_event_in), .stb_cond_in(stb_cond_in), .nv_psc(nv_psc),
        .selftest_done(selftest_done), .selftest_fail(selftest_fail),
        .meas_start_q(meas_start_q), .wait_trig_q(wait_trig_q), .scanning_q(scanning_q),
        .srq_q(srq_q), .stb_q(stb_q), .cls_pulse_q(cls_pulse_q),
        .selftest_start_q(selftest_start_q), .hist_stat_on_q(hist_stat_on_q),
        .psc_q(psc_q));
    host_model host_model_inst (
        .mclk(mclk), .cmd_ready_q(cmd_ready_q), .rsp_valid_q(rsp_valid_q),
        .rsp_data_q(rsp_data_q), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_arg(cmd_arg), .rsp_ready(rsp_ready));
    always #50 mclk = ~mclk;
    // Start spacing
    always @(posedge mclk) begin
        cyc++;
        if (meas_start_q) begin
            n_meas++;
            gap = cyc - t_last;
            t_last = cyc;
        end
    end
    // Scan ends slen cycles after start
    always @(posedge mclk) begin
        #1;
        sc = meas_start_q ? 1 : (scanning_q ? sc + 1 : 0);
        scan_done = (sc == slen);
    end
    // Self-test finishes a few cycles after it starts
    always @(posedge selftest_start_q) begin
        repeat (5) @(posedge mclk);
        #1 selftest_done = 1;
        @(posedge mclk);
        #1 selftest_done = 0;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic cmd(input logic [4:0] c, input logic [31:0] a);
        host_model_inst.xfer(c, a, 1'b0, d);
    endtask
    task automatic qry(input logic [4:0] c, input logic [31:0] e);
        host_model_inst.xfer(c, 32'h0, 1'b1, d);
        chk(d, e);
    endtask
    // Select, count, arm
    task automatic arm(input logic [2:0] s, input logic [31:0] n);
        n_meas = 0;
        cmd(`CMD_SRC_SET, {29'h0, s});
        cmd(`CMD_COUNT_SET, n);
        cmd(`CMD_INIT, 32'h0);
    endtask
    task automatic do_rst(input logic p);
        nv_psc = p;
        rst = 1;
        tick(2);
        rst = 0;
    endtask
    task automatic conclude;
        $display("errors %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (10000) @(posedge mclk);
        n_errors++;
        conclude;
    end
    initial begin
        tick(10);
        rst = 0;
        chk({cmd_ready_q, rsp_valid_q, psc_q, hist_stat_on_q}, 4'hA);
        for (int k = 0; k < 8; k++) begin
            cmd(`CMD_SRC_SET, k);
            qry(`CMD_SRC_GET, k);
        end
        foreach (rows[i]) begin
            if (rows[i].q) begin
                qry(rows[i].c, rows[i].v);
            end else begin
                cmd(rows[i].c, rows[i].v);
            end
        end
        // Event latch
        cmd(`CMD_CLS, 32'h0);
        chk(cls_pulse_q, 1'h1);
        qry(`CMD_ESR_GET, 32'h0);
        std_event_in[3] = 1;
        tick(2);
        qry(`CMD_ESR_GET, 32'h08);
        qry(`CMD_ESR_GET, 32'h0);
        std_event_in[3] = 0;
        tick(1);
        std_event_in[3] = 1;
        cmd(`CMD_ESE_SET, 32'h08);
        cmd(`CMD_SRE_SET, 32'h20);
        tick(3);
        chk({srq_q, stb_q[5]}, 2'h3);
        cmd(`CMD_CLS, 32'h0);
        tick(3);
        chk({srq_q, stb_q[5]}, 2'h0);
        // Live status byte, slow host
        cmd(`CMD_ESE_SET, 32'h0);
        cmd(`CMD_SRE_SET, 32'h0);
        stb_cond_in = 8'h81;
        host_model_inst.slow = 4;
        qry(`CMD_STB_GET, 32'h81);
        qry(`CMD_STB_GET, 32'h81);
        host_model_inst.slow = 0;
        cmd(`CMD_SRE_SET, 32'h01);
        tick(3);
        chk(srq_q, 1'h1);
        stb_cond_in = 8'h00;
        tick(3);
        chk(srq_q, 1'h0);
        // Completion waits for busy work
        ops_busy = 1;
        cmd(`CMD_OPC, 32'h0);
        qry(`CMD_ESR_GET, 32'h0);
        t0 = cyc;
        fork
            qry(`CMD_OPC_GET, 32'h1);
            begin
                tick(20);
                ops_busy = 0;
            end
        join
        chk(cyc - t0 > 20, 1'h1);
        qry(`CMD_ESR_GET, 32'h1);
        for (int f = 0; f < 2; f++) begin
            selftest_fail = f;
            qry(`CMD_TST, f);
        end
        // Setup slots
        cmd(`CMD_SRC_SET, `SRC_BUS);
        cmd(`CMD_SAV, 32'h1);
        cmd(`CMD_SRC_SET, `SRC_EXT);
        cmd(`CMD_RCL, 32'h1);
        qry(`CMD_SRC_GET, `SRC_BUS);
        cmd(`CMD_SAV, 32'h0);
        cmd(`CMD_RCL, 32'h0);
        qry(`CMD_SRC_GET, `SRC_IMM);
        // Immediate, count two
        arm(`SRC_IMM, 32'h2);
        tick(40);
        chk({n_meas[3:0], wait_trig_q}, 5'h04);
        // Bus trigger only while waiting
        arm(`SRC_BUS, 32'h1);
        tick(5);
        chk({n_meas[3:0], wait_trig_q}, 5'h01);
        cmd(`CMD_TRG, 32'h0);
        tick(10);
        cmd(`CMD_TRG, 32'h0);
        tick(10);
        chk(n_meas, 32'h1);
        // Falling slope; two early edges fold into one
        slen = 12;
        cmd(`CMD_SLOPE_SET, 32'h0);
        arm(`SRC_EXT, 32'h3);
        ext_trig_in = 1;
        tick(3);
        chk(n_meas, 32'h0);
        for (int p = 0; p < 3; p++) begin
            ext_trig_in = 0;
            tick(3);
            ext_trig_in = 1;
            tick(1);
        end
        tick(40);
        chk({n_meas[3:0], wait_trig_q}, 5'h05);
        slen = 3;
        for (int k = 0; k < 4; k++) begin
            arm(`SRC_ALARM1 + k, 32'h1);
            alarm_in[k] = 1;
            tick(3);
            alarm_in[k] = 0;
            tick(10);
            chk(n_meas, 32'h1);
        end
        // Timer spacing
        cmd(`CMD_TIMER_SET, 32'h3);
        cmd(`CMD_TIMER_SET, 32'h57E41);
        arm(`SRC_TIM, 32'h2);
        tick(45);
        chk({gap, n_meas}, {32'h1E, 32'h2});
        cmd(`CMD_TIMER_SET, 32'h0);
        arm(`SRC_TIM, 32'h3);
        tick(40);
        chk(n_meas, 32'h3);
        cmd(`CMD_RST, 32'h0);
        arm(`SRC_TIM, 32'h2);
        tick(120);
        chk({gap, n_meas}, {32'h64, 32'h2});
        // Power-on clear flag
        cmd(`CMD_ESE_SET, 32'h55);
        do_rst(0);
        qry(`CMD_ESE_GET, 32'h55);
        do_rst(1);
        qry(`CMD_ESE_GET, 32'h0);
        conclude;
    end
endmodule // trigger_status_test
